// ---- rtl/rwss_pkg.sv ----
package rwss_pkg;

    // register offsets on the plain register port
    localparam logic [8:0] RWSS_ADDR_WDCLR = 9'h0E3;
    localparam logic [8:0] RWSS_ADDR_SSC   = 9'h0FF;
    localparam logic [8:0] RWSS_ADDR_OSC   = 9'h1E0;
    localparam logic [8:0] RWSS_ADDR_CMP   = 9'h1E4;
    localparam logic [8:0] RWSS_ADDR_DUTY  = 9'h1EB;

    // system status and control layout
    localparam logic [7:0] RWSS_SSC_RESET  = 8'h10;
    localparam int         RWSS_SSC_GIES   = 7;
    localparam int         RWSS_SSC_WATCHDOG_STATUS_FLAG   = 5;
    localparam int         RWSS_SSC_POWER_ON_STATUS_FLAG   = 4;
    localparam int         RWSS_SSC_SLEEP  = 3;
    localparam int         RWSS_SSC_STOP   = 0;

    // oscillator control: clock select and sleep period select
    localparam logic [7:0] RWSS_OSC_RESET  = 8'h00;
    localparam int         RWSS_OSC_CLKSEL = 1;
    localparam int         RWSS_OSC_PER_LO = 3;

    // monitor duty trim and comparator snapshot layout
    localparam logic [7:0] RWSS_DUTY_RESET = 8'h00;
    localparam int         RWSS_DUTY_LO    = 6;
    localparam int         RWSS_CMP_LVD    = 1;
    localparam int         RWSS_CMP_PPOR   = 0;

    // watchdog clear behaviour
    localparam logic [7:0] RWSS_WD_KEY     = 8'h38;
    localparam logic [1:0] RWSS_WD_LIMIT   = 2'h3;

    // oscillator recovery after sleep, in low-power clock periods
    localparam logic [1:0] RWSS_REC_CYCLES = 2'h3;

    // start-up hold after power-on
    localparam int         RWSS_HOLD_MS    = 20;
    localparam int         RWSS_CLK_HZ     = 20000000;
    localparam int         RWSS_HOLD_CYC   = RWSS_HOLD_MS * (RWSS_CLK_HZ / 1000);
    localparam logic [15:0] RWSS_START_ADDR = 16'h0000;

    // sleep timer periods in low-power clock periods, minus one
    localparam logic [12:0] RWSS_PER_0 = 13'h003F;
    localparam logic [12:0] RWSS_PER_1 = 13'h01FF;
    localparam logic [12:0] RWSS_PER_2 = 13'h03FF;
    localparam logic [12:0] RWSS_PER_3 = 13'h1FFF;

    // monitor duty periods in low-power clock periods, minus one
    localparam logic [8:0] RWSS_DUTY_0 = 9'h07F;
    localparam logic [8:0] RWSS_DUTY_1 = 9'h1FF;
    localparam logic [8:0] RWSS_DUTY_2 = 9'h01F;
    localparam logic [8:0] RWSS_DUTY_3 = 9'h007;

    // sleep sequencer states
    typedef enum logic [2:0] {
        RWSS_RUN     = 3'b000,
        RWSS_REQ     = 3'b001,
        RWSS_ACKED   = 3'b010,
        RWSS_ASLEEP  = 3'b011,
        RWSS_SYNCED  = 3'b100,
        RWSS_SETTLE  = 3'b101,
        RWSS_RELEASE = 3'b110
    } rwss_state_t;

endpackage : rwss_pkg

// ---- rtl/rwss_reset_watchdog_sleep_sequencer.sv ----
`timescale 1ns/100ps

module rwss_reset_watchdog_sleep_sequencer
    import rwss_pkg::*;
#(
    parameter int IRQ_W     = 8,
    parameter int HOLD_CYC  = RWSS_HOLD_CYC
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [8:0]       regAddr,
    input  wire logic [7:0]       regWrData,
    input  wire logic             regWr,
    input  wire logic             regRd,
    output logic      [7:0]       regRdData,
    input  wire logic             lpoClk,
    input  wire logic             supplyLow,
    input  wire logic             pporTrip,
    input  wire logic             lvdTrip,
    input  wire logic [IRQ_W-1:0] irqPendingUnmasked,
    input  wire logic             globalIrqEnable,
    input  wire logic             busRequestAck,
    output logic                  busRequest,
    output logic                  systemPowerDown,
    output logic                  fastOscEnable,
    output logic                  monitorEnable,
    output logic                  intOscReady,
    output logic                  cpuHold,
    output logic      [15:0]      cpuStartAddr,
    output logic                  cpuClkSelExt,
    output logic                  cpuStop,
    output logic                  resumeOneInstr,
    output logic                  sleepTimerIrq,
    output logic                  watchdogResetEvent
);

    localparam int HW = $clog2(HOLD_CYC + 1);

    // sleep period lookup, used only by the sleep timer overflow compare
    function automatic logic [12:0] rwssPeriod(input logic [1:0] sel);
        logic [12:0] p;
        p = RWSS_PER_0;
        unique case (sel)
            2'h0: p = RWSS_PER_0;
            2'h1: p = RWSS_PER_1;
            2'h2: p = RWSS_PER_2;
            2'h3: p = RWSS_PER_3;
        endcase
        return p;
    endfunction : rwssPeriod

    // monitor duty lookup
    function automatic logic [8:0] rwssDuty(input logic [1:0] sel);
        logic [8:0] d;
        d = RWSS_DUTY_0;
        unique case (sel)
            2'h0: d = RWSS_DUTY_0;
            2'h1: d = RWSS_DUTY_1;
            2'h2: d = RWSS_DUTY_2;
            2'h3: d = RWSS_DUTY_3;
        endcase
        return d;
    endfunction : rwssDuty

    logic [3:0]  syncA_q;
    logic [3:0]  syncB_q;
    logic        lpoLast_q;
    logic        lpoRise;
    logic        lpoFall;
    logic        porReq;
    logic        sysRst;
    logic        anyRst;
    logic [HW-1:0] holdCnt_q;
    logic        watchdog_status_flag_q;
    logic        power_on_status_flag_q;
    logic        sleep_q;
    logic        stop_q;
    logic [7:0]  osc_q;
    logic [7:0]  duty_q;
    logic [1:0]  cmp_q;
    logic [12:0] sleepCnt_q;
    logic        sleepOvf;
    logic [1:0]  wdCnt_q;
    logic        wdEvent_q;
    logic        wdWr;
    logic        wdKey;
    rwss_state_t state_q;
    logic        wakeReq_q;
    logic        wakeNow;
    logic [1:0]  recCnt_q;
    logic [8:0]  dutyCnt_q;
    logic        sscWr;

    // two-flop synchronisers for lpo, supply, ppor and lvd pins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            syncA_q   <= 4'h0;
            syncB_q   <= 4'h0;
            lpoLast_q <= 1'b0;
        end else begin
            syncA_q   <= {lvdTrip, pporTrip, supplyLow, lpoClk};
            syncB_q   <= syncA_q;
            lpoLast_q <= syncB_q[0];
        end
    end

    assign lpoRise = syncB_q[0] & ~lpoLast_q;
    assign lpoFall = ~syncB_q[0] & lpoLast_q;
    assign porReq  = syncB_q[1];
    assign sysRst  = ~rstn | porReq;
    assign anyRst  = sysRst | wdEvent_q;
    assign wdWr    = regWr & (regAddr == RWSS_ADDR_WDCLR);
    assign wdKey   = wdWr & (regWrData == RWSS_WD_KEY);
    assign sscWr   = regWr & (regAddr == RWSS_ADDR_SSC);

    // start-up hold counter, restarted by every power-on event
    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            holdCnt_q <= '0;
        end else if (holdCnt_q != HW'(HOLD_CYC)) begin
            holdCnt_q <= holdCnt_q + HW'(1);
        end
    end

    assign cpuHold      = sysRst | (holdCnt_q != HW'(HOLD_CYC));
    assign cpuStartAddr = RWSS_START_ADDR;

    // reset-cause flags survive a watchdog reset, only power-on rewrites them
    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            power_on_status_flag_q <= RWSS_SSC_RESET[RWSS_SSC_POWER_ON_STATUS_FLAG];
            watchdog_status_flag_q <= RWSS_SSC_RESET[RWSS_SSC_WATCHDOG_STATUS_FLAG];
        end else begin
            if (wdEvent_q) begin
                watchdog_status_flag_q <= 1'b1;
            end else if (sscWr && !regWrData[RWSS_SSC_WATCHDOG_STATUS_FLAG]) begin
                watchdog_status_flag_q <= 1'b0;
            end
            if (sscWr && !regWrData[RWSS_SSC_POWER_ON_STATUS_FLAG]) begin
                power_on_status_flag_q <= 1'b0;
            end
        end
    end

    // sleep and stop bits; hardware clears sleep once wake completes
    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            sleep_q <= RWSS_SSC_RESET[RWSS_SSC_SLEEP];
            stop_q  <= RWSS_SSC_RESET[RWSS_SSC_STOP];
        end else begin
            if (state_q == RWSS_RELEASE && lpoFall) begin
                sleep_q <= 1'b0;
            end else if (sscWr) begin
                sleep_q <= regWrData[RWSS_SSC_SLEEP];
            end
            if (sscWr) begin
                stop_q <= regWrData[RWSS_SSC_STOP];
            end
        end
    end

    assign cpuStop = stop_q;  // halt holds the core even after wake

    // oscillator control and monitor duty registers
    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            osc_q  <= RWSS_OSC_RESET;
            duty_q <= RWSS_DUTY_RESET;
        end else begin
            if (regWr && regAddr == RWSS_ADDR_OSC) begin
                osc_q <= regWrData;
            end
            if (state_q == RWSS_REQ) begin
                osc_q[RWSS_OSC_CLKSEL] <= 1'b0;
            end
            if (regWr && regAddr == RWSS_ADDR_DUTY) begin
                duty_q <= regWrData;
            end
        end
    end

    assign cpuClkSelExt = osc_q[RWSS_OSC_CLKSEL];

    // sleep timer on low-power clock edges
    assign sleepOvf = lpoRise & (sleepCnt_q >= rwssPeriod(osc_q[RWSS_OSC_PER_LO +: 2]));

    always_ff @(posedge core_clk) begin
        if (anyRst || wdKey) begin
            sleepCnt_q <= 13'h0000;
        end else if (sleepOvf) begin
            sleepCnt_q <= 13'h0000;
        end else if (lpoRise) begin
            sleepCnt_q <= sleepCnt_q + 13'h0001;
        end
    end

    // overflow pulse; the pulse output is cleared by any reset
    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            sleepTimerIrq <= 1'b0;
        end else begin
            sleepTimerIrq <= sleepOvf;
        end
    end

    // watchdog: counts overflows, fires at three once enabled
    always_ff @(posedge core_clk) begin
        if (anyRst || wdWr || power_on_status_flag_q) begin
            // a disabled watchdog holds zero, so enabling it never fires at once
            wdCnt_q <= 2'h0;
        end else if (sleepOvf && wdCnt_q != RWSS_WD_LIMIT) begin
            wdCnt_q <= wdCnt_q + 2'h1;
        end
    end

    // one-cycle reset pulse; it clears itself through anyRst
    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            wdEvent_q <= 1'b0;
        end else begin
            wdEvent_q <= (wdCnt_q == RWSS_WD_LIMIT) & ~power_on_status_flag_q;
        end
    end

    assign watchdogResetEvent = wdEvent_q;

    // wake request: held so a short pulse still finishes the sequence
    assign wakeNow = |irqPendingUnmasked;

    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            wakeReq_q <= 1'b0;
        end else if (state_q == RWSS_RELEASE && lpoFall) begin
            wakeReq_q <= 1'b0;
        end else if (wakeNow && state_q != RWSS_RUN) begin
            wakeReq_q <= 1'b1;
        end
    end

    // sleep sequencer; the ack wait state stands in for the falling edge
    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            state_q <= RWSS_RUN;
        end else begin
            unique case (state_q)
                RWSS_RUN: begin
                    if (sscWr && regWrData[RWSS_SSC_SLEEP]) begin
                        state_q <= RWSS_REQ;
                    end
                end
                RWSS_REQ: begin
                    if (busRequestAck) begin
                        state_q <= RWSS_ACKED;
                    end
                end
                RWSS_ACKED: begin
                    state_q <= RWSS_ASLEEP;
                end
                RWSS_ASLEEP: begin
                    if ((wakeReq_q || wakeNow) && lpoFall) begin
                        state_q <= RWSS_SYNCED;
                    end
                end
                RWSS_SYNCED: begin
                    if (lpoRise) begin
                        state_q <= RWSS_SETTLE;
                    end
                end
                RWSS_SETTLE: begin
                    if (lpoRise) begin
                        state_q <= RWSS_RELEASE;
                    end
                end
                RWSS_RELEASE: begin
                    if (lpoFall) begin
                        state_q <= RWSS_RUN;
                    end
                end
                default: state_q <= RWSS_RUN;
            endcase
        end
    end

    // bus request rises with the sleep write and falls at release
    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            busRequest <= 1'b0;
        end else if (state_q == RWSS_RELEASE && lpoFall) begin
            busRequest <= 1'b0;
        end else if (state_q == RWSS_RUN && sscWr && regWrData[RWSS_SSC_SLEEP]) begin
            busRequest <= 1'b1;
        end
    end

    // power-down spans asleep and the synced wait
    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            systemPowerDown <= 1'b0;
        end else if (state_q == RWSS_ACKED) begin
            systemPowerDown <= 1'b1;
        end else if (state_q == RWSS_SYNCED && lpoRise) begin
            systemPowerDown <= 1'b0;
        end
    end

    assign fastOscEnable = ~systemPowerDown;

    // comparator snapshot taken once the references have settled
    always_ff @(posedge core_clk) begin
        if (sysRst) begin
            cmp_q <= 2'h0;
        end else if (state_q == RWSS_SETTLE && lpoRise) begin
            cmp_q <= {syncB_q[3], syncB_q[2]};
        end
    end

    // oscillator recovery: three low-power periods after power-down ends
    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            recCnt_q <= RWSS_REC_CYCLES;
        end else if (systemPowerDown) begin
            recCnt_q <= 2'h0;
        end else if (lpoRise && recCnt_q != RWSS_REC_CYCLES) begin
            recCnt_q <= recCnt_q + 2'h1;
        end
    end

    assign intOscReady = (recCnt_q == RWSS_REC_CYCLES);

    // one pulse at release tells the core to run one instruction first
    always_ff @(posedge core_clk) begin
        if (anyRst) begin
            resumeOneInstr <= 1'b0;
        end else begin
            resumeOneInstr <= (state_q == RWSS_RELEASE) & lpoFall;
        end
    end

    // duty-cycled supply monitor while asleep; latency grows with the ratio
    always_ff @(posedge core_clk) begin
        if (anyRst || !systemPowerDown) begin
            dutyCnt_q <= 9'h000;
        end else if (lpoRise) begin
            if (dutyCnt_q >= rwssDuty(duty_q[RWSS_DUTY_LO +: 2])) begin
                dutyCnt_q <= 9'h000;
            end else begin
                dutyCnt_q <= dutyCnt_q + 9'h001;
            end
        end
    end

    assign monitorEnable = ~systemPowerDown | (dutyCnt_q == 9'h000);

    // read port; watchdog clear is write-only and reads zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                RWSS_ADDR_SSC:  regRdData <= {globalIrqEnable, 1'b0, watchdog_status_flag_q, power_on_status_flag_q,
                                              sleep_q, 2'h0, stop_q};
                RWSS_ADDR_OSC:  regRdData <= osc_q;
                RWSS_ADDR_DUTY: regRdData <= {duty_q[7:6], 6'h00};
                RWSS_ADDR_CMP:  regRdData <= {6'h00, cmp_q};
                default:        regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule : rwss_reset_watchdog_sleep_sequencer

// ---- sim/rwss_asserts.sv ----
`timescale 1ns/100ps

module rwss_checker
    import rwss_pkg::*;
#(
    parameter int IRQ_W    = 8,
    parameter int HOLD_CYC = 20
) (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic [8:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       lpoClk,
    input wire logic       busRequestAck,
    input wire logic       busRequest,
    input wire logic       systemPowerDown,
    input wire logic       fastOscEnable,
    input wire logic       monitorEnable,
    input wire logic       intOscReady,
    input wire logic       cpuHold,
    input wire logic       cpuClkSelExt,
    input wire logic       resumeOneInstr,
    input wire logic       watchdogResetEvent
);
    // one clock domain, quiet while in reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    a_req_on_sleep: assert property (
        regWr && regAddr == RWSS_ADDR_SSC && regWrData[3] && !busRequest |=> busRequest)
        else $error("no request after sleep write");
    a_pd_after_ack: assert property ($rose(busRequestAck) |-> ##[1:3] systemPowerDown)
        else $error("power-down late after acknowledge");
    a_pd_needs_req: assert property (systemPowerDown |-> busRequest && busRequestAck)
        else $error("power-down without handshake");
    a_fast_osc_off: assert property (fastOscEnable == !systemPowerDown)
        else $error("fast oscillator wrong for power state");
    a_monitor_awake: assert property (!systemPowerDown |-> monitorEnable)
        else $error("monitor off while awake");
    a_clk_internal: assert property ($rose(systemPowerDown) |-> !cpuClkSelExt)
        else $error("external clock kept into sleep");
    // edges reach the logic a few cycles late, so the pin still shows the level
    a_pd_drop_rise: assert property ($fell(systemPowerDown) |-> lpoClk)
        else $error("power-down dropped off a rising slow edge");
    a_osc_recovery: assert property ($fell(systemPowerDown) |-> !intOscReady [*8])
        else $error("oscillator ready too early");
    a_req_drop_fall: assert property ($fell(busRequest) |-> !lpoClk)
        else $error("request dropped off a falling slow edge");
    a_resume_pulse: assert property (
        $fell(busRequest) |-> resumeOneInstr ##1 !resumeOneInstr)
        else $error("resume pulse missing");
    a_hold_start: assert property ($rose(rstn) |-> cpuHold [*8])
        else $error("processor not held after reset");

    c_sleep: cover property ($rose(systemPowerDown));
    c_wake: cover property ($fell(busRequest));
    c_wdog: cover property (watchdogResetEvent);
endmodule : rwss_checker

bind rwss_reset_watchdog_sleep_sequencer rwss_checker #(.IRQ_W(IRQ_W), .HOLD_CYC(HOLD_CYC))
u_checker (
    .core_clk, .rstn, .regAddr, .regWrData, .regWr, .lpoClk, .busRequestAck, .busRequest,
    .systemPowerDown, .fastOscEnable, .monitorEnable, .intOscReady, .cpuHold,
    .cpuClkSelExt, .resumeOneInstr, .watchdogResetEvent
);

// ---- sim/rwss_cpu_model.sv ----
`timescale 1ns/100ps

module rwss_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       busRequest,
    input  wire logic [3:0] ackDelay,
    output logic            busRequestAck
);
    logic [3:0] waitCnt_q;

    // ackDelay extra cycles stand in for a slow instruction boundary
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            busRequestAck <= 1'b0;
            waitCnt_q     <= 4'h0;
        end else if (!busRequest) begin
            busRequestAck <= 1'b0;
            waitCnt_q     <= 4'h0;
        end else if (waitCnt_q == ackDelay) begin
            busRequestAck <= 1'b1;
        end else begin
            waitCnt_q <= waitCnt_q + 4'h1;
        end
    end
endmodule : rwss_cpu_model

// ---- sim/rwss_reset_watchdog_sleep_sequencer_test.sv ----
`timescale 1ns/100ps

module rwss_reset_watchdog_sleep_sequencer_test
    import rwss_pkg::*;
;
    localparam int HOLD = 20;

    logic        core_clk, rstn, regWr, regRd, lpoClk, supplyLow, pporTrip, lvdTrip;
    logic        globalIrqEnable, busRequestAck, busRequest, systemPowerDown;
    logic        fastOscEnable, intOscReady, cpuHold, cpuClkSelExt, cpuStop;
    logic        resumeOneInstr, sleepTimerIrq, watchdogResetEvent;
    logic [8:0]  regAddr;
    logic [7:0]  regWrData, regRdData, irqPendingUnmasked;
    logic [15:0] cpuStartAddr;
    logic [3:0]  ackDelay;
    logic [2:0]  lpoDiv;
    int          fail_count, tests_run, irqCount, wdCount, resumeCount;

    rwss_reset_watchdog_sleep_sequencer #(.IRQ_W(8), .HOLD_CYC(HOLD)) dut (
        .core_clk, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .lpoClk,
        .supplyLow, .pporTrip, .lvdTrip, .irqPendingUnmasked, .globalIrqEnable,
        .busRequestAck, .busRequest, .systemPowerDown, .fastOscEnable, .monitorEnable(),
        .intOscReady, .cpuHold, .cpuStartAddr, .cpuClkSelExt, .cpuStop, .resumeOneInstr,
        .sleepTimerIrq, .watchdogResetEvent
    );

    rwss_cpu_model u_cpu (.core_clk, .rstn, .busRequest, .ackDelay, .busRequestAck);

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // slow clock at 16 core periods: far too fast, but keeps watchdog runs short
    always @(posedge core_clk) begin
        lpoDiv <= lpoDiv + 3'h1;
        if (lpoDiv == 3'h7)
            lpoClk <= ~lpoClk;
    end

    // pulse tallies, sampled before the edge updates land
    always @(posedge core_clk) begin
        if (sleepTimerIrq === 1'b1)
            irqCount++;
        if (watchdogResetEvent === 1'b1)
            wdCount++;
        if (resumeOneInstr === 1'b1)
            resumeCount++;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chkb

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge core_clk);
        regWr     <= 1'b0;
        #1;
    endtask : wr

    task automatic rdc(input logic [8:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd   <= 1'b0;
        #1;
        chk({8'h00, regRdData}, {8'h00, e});
    endtask : rdc

    // bounded wait for a level, left just after an edge
    task automatic waitv(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : waitv

    task automatic waitIrq(input int k);
        int n;
        int i0;
        n = 0;
        i0 = irqCount;
        while (irqCount < i0 + k && n < 2000 * k) begin
            @(posedge core_clk);
            n++;
        end
        #1;
    endtask : waitIrq

    task automatic t_reset;
        #1;
        chk(cpuStartAddr, 16'h0000);
        repeat (HOLD - 2) @(posedge core_clk);
        #1;
        chkb(cpuHold, 1'b1);
        repeat (6) @(posedge core_clk);
        #1;
        chkb(cpuHold, 1'b0);
        rdc(RWSS_ADDR_SSC, 8'h10);
        rdc(RWSS_ADDR_OSC, RWSS_OSC_RESET);
        rdc(RWSS_ADDR_DUTY, RWSS_DUTY_RESET);
        rdc(RWSS_ADDR_WDCLR, 8'h00);
        rdc(9'h155, 8'h00);
        wr(RWSS_ADDR_DUTY, 8'hC0);
        rdc(RWSS_ADDR_DUTY, 8'hC0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_flags;
        int i0;
        wr(RWSS_ADDR_SSC, 8'h31);
        chkb(cpuStop, 1'b1);
        rdc(RWSS_ADDR_SSC, 8'h11);
        wr(RWSS_ADDR_SSC, 8'h30);
        chkb(cpuStop, 1'b0);
        rdc(RWSS_ADDR_SSC, 8'h10);
        i0 = irqCount;
        waitIrq(4);
        chk(16'(irqCount - i0), 16'h0004);
        chk(16'(wdCount), 16'h0000);
        $display("test flags done");
    endtask : t_flags

    task automatic t_sleep(input logic [3:0] dly, input int idx, input logic gie);
        int r0;
        @(posedge core_clk);
        ackDelay        <= dly;
        globalIrqEnable <= gie;
        pporTrip        <= 1'b1;
        wr(RWSS_ADDR_OSC, 8'h02);
        chkb(cpuClkSelExt, 1'b1);
        // flag bits written as one so the power-on flag survives the sleep write
        wr(RWSS_ADDR_SSC, 8'h38);
        chkb(busRequest, 1'b1);
        waitv(systemPowerDown, 1'b1, 20);
        chkb(systemPowerDown, 1'b1);
        chkb(fastOscEnable, 1'b0);
        chkb(cpuClkSelExt, 1'b0);
        repeat (100) @(posedge core_clk);
        irqPendingUnmasked[idx] <= 1'b1;
        #1;
        chkb(systemPowerDown, 1'b1);
        r0 = resumeCount;
        waitv(systemPowerDown, 1'b0, 60);
        chkb(systemPowerDown, 1'b0);
        chkb(intOscReady, 1'b0);
        waitv(busRequest, 1'b0, 40);
        chkb(busRequest, 1'b0);
        waitv(intOscReady, 1'b1, 60);
        chkb(intOscReady, 1'b1);
        chk(16'(resumeCount - r0), 16'h0001);
        @(posedge core_clk);
        irqPendingUnmasked <= 8'h00;
        pporTrip           <= 1'b0;
        rdc(RWSS_ADDR_CMP, 8'h01);
        rdc(RWSS_ADDR_SSC, {gie, 7'h10});
        $display("test sleep done");
    endtask : t_sleep

    task automatic t_watchdog;
        int i0;
        int w0;
        int n;
        @(posedge core_clk);
        globalIrqEnable <= 1'b0;
        wr(RWSS_ADDR_SSC, 8'h00);
        rdc(RWSS_ADDR_SSC, 8'h00);
        wr(RWSS_ADDR_WDCLR, 8'h38);
        i0 = irqCount;
        w0 = wdCount;
        n = 0;
        while (wdCount == w0 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
        #1;
        chk(16'(wdCount - w0), 16'h0001);
        chk(16'(irqCount - i0), 16'h0003);
        rdc(RWSS_ADDR_SSC, 8'h20);
        wr(RWSS_ADDR_SSC, 8'h20);
        rdc(RWSS_ADDR_SSC, 8'h20);
        wr(RWSS_ADDR_SSC, 8'h00);
        rdc(RWSS_ADDR_SSC, 8'h00);
        w0 = wdCount;
        repeat (5) begin
            waitIrq(1);
            wr(RWSS_ADDR_WDCLR, 8'h11);
        end
        chk(16'(wdCount - w0), 16'h0000);
        $display("test watchdog done");
    endtask : t_watchdog

    task automatic t_supply;
        int w0;
        @(posedge core_clk);
        supplyLow <= 1'b1;
        repeat (5) @(posedge core_clk);
        supplyLow <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        chkb(cpuHold, 1'b1);
        rdc(RWSS_ADDR_SSC, 8'h10);
        w0 = wdCount;
        waitIrq(4);
        chk(16'(wdCount - w0), 16'h0000);
        $display("test supply done");
    endtask : t_supply

    // hang guard, well past the expected run length
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        tally_and_finish();
    end

    initial begin
        {rstn, regWr, regRd, lpoClk, supplyLow, pporTrip, lvdTrip, globalIrqEnable} = 8'h00;
        regAddr = 9'h000;
        regWrData = 8'h00;
        irqPendingUnmasked = 8'h00;
        ackDelay = 4'h0;
        lpoDiv = 3'h0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_flags();
        t_sleep(4'h0, 0, 1'b0);
        t_sleep(4'h3, 5, 1'b1);
        t_watchdog();
        t_supply();
        tally_and_finish();
    end
endmodule : rwss_reset_watchdog_sleep_sequencer_test
